// [src/asrc_pkg.sv]
// Package: constants and types for the converter state and reset control block
package asrc_pkg;

  // Clock rate of core_clk_i
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS     = 50;

  // Timing figures in their own unit
  localparam int unsigned RST_LOW_MIN_NS    = 100;
  localparam int unsigned RST_EXIT_NS       = 1000;
  localparam int unsigned CONV_MIN_NS       = 300;
  localparam int unsigned CONV_MAX_NS       = 600;

  // Cycle counts: least times round up, longest round down, never below one
  localparam int unsigned RST_LOW_MIN_CYC   =
    ((RST_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((RST_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned RST_EXIT_CYC      =
    ((RST_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((RST_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned CONV_MIN_CYC      =
    ((CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned CONV_MAX_CYC      =
    (CONV_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (CONV_MAX_NS / CLK_PERIOD_NS);

  // Result format
  localparam int unsigned RES_W             = 16;
  localparam logic [15:0] CODE_NEG_FS       = 16'h8000;
  localparam logic [15:0] CODE_POS_FS       = 16'h7fff;
  localparam logic [15:0] CODE_ZERO         = 16'h0000;

  // Counter width for all timing counts
  localparam int unsigned CNT_W             = 8;

  // Dither generator seed, arbitrary nonzero value
  localparam logic [7:0]  LFSR_SEED         = 8'h5a;

  // Configuration register default
  localparam logic [7:0]  CFG_DEFAULT       = 8'h00;

  typedef enum logic [1:0]
  {
    ST_RESET = 2'b00,
    ST_ACQ   = 2'b01,
    ST_CONV  = 2'b10
  } asrc_state_e;

endpackage

// [src/asrc_converter.sv]
// Converter core: conversion timing, sample hold and result coding
module asrc_converter
  import asrc_pkg::*;
(
  // Clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   nrst_i,
  // From interface side
  input  wire logic                   rst_sync_n_i,
  input  wire logic                   start_i,
  input  wire logic signed [17:0]     pos_sample_i,
  input  wire logic signed [17:0]     neg_sample_i,
  // To interface side
  output logic                        conversion_active_status_o,
  output logic                        done_o,
  output logic [RES_W-1:0]            result_o
);

  typedef struct packed
  {
    logic              busy;
    logic              status;
    logic              done;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  len;
    logic [7:0]        lfsr;
    logic signed [17:0] held_pos;
    logic signed [17:0] held_neg;
    logic [15:0]       result;
  } asrc_conv_s;

  asrc_conv_s r;
  asrc_conv_s next_r;

  // Clamp the held difference into the 16-bit twos-complement code
  function automatic logic [15:0] code_of(input logic signed [18:0] diff);
    if (diff < $signed(19'(-32768)))
      code_of = CODE_NEG_FS;
    else if (diff > $signed(19'(32767)))
      code_of = CODE_POS_FS;
    else
      code_of = diff[15:0];
  endfunction

  localparam logic [CNT_W-1:0] MIN_C  = CNT_W'(CONV_MIN_CYC);
  localparam logic [CNT_W-1:0] SPAN_C = CNT_W'(CONV_MAX_CYC - CONV_MIN_CYC + 1);

  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.lfsr = {r.lfsr[6:0], r.lfsr[7] ^ r.lfsr[5] ^ r.lfsr[4] ^ r.lfsr[3]};
    if (!rst_sync_n_i)
    begin
      next_r.busy   = 1'b0;
      next_r.status = 1'b1;
    end
    else if (!r.busy)
    begin
      // Inputs tracked separately while acquiring
      next_r.held_pos = pos_sample_i;
      next_r.held_neg = neg_sample_i;
      if (start_i)
      begin
        next_r.busy   = 1'b1;
        next_r.status = 1'b0;
        next_r.cnt    = '0;
        // Length varies per conversion, bounded min..max
        next_r.len    = MIN_C + CNT_W'(r.lfsr % SPAN_C) - CNT_W'(1);
      end
    end
    else
    begin
      // Timed only by the internal clock
      next_r.cnt = r.cnt + CNT_W'(1);
      if (r.cnt >= r.len)
      begin
        next_r.busy   = 1'b0;
        next_r.status = 1'b1;
        next_r.done   = 1'b1;
        // Difference of the held samples
        next_r.result = code_of(19'(r.held_pos) - 19'(r.held_neg));
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      r <= '{busy: 1'b0, status: 1'b1, done: 1'b0, cnt: '0, len: '0,
             lfsr: LFSR_SEED, held_pos: '0, held_neg: '0, result: CODE_ZERO};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign conversion_active_status_o = r.status;
  assign done_o                     = r.done;
  assign result_o                   = r.result;

endmodule

// [src/asrc_ctrl.sv]
// Top: functional state and reset control of the converter device
// Functional notes
// - Three states: reset, acquisition, conversion
// - Reset input acts asynchronously
// - Reset: config defaults, strobe low, outputs hiZ
// - Exit delay, then acquisition, strobe high
// - Only convert-start and conversion end change state while released
// - Conversion timed by internal oscillator
// - Conversion length varies within min/max
// - Conversion end returns to acquisition automatically
// - Converter core exchanges reset, start, status, result
// - Result is 16-bit twos complement
// - Result saturates at 8000 and 7FFF
// - Transfers timed internally, by serial clock, both; code paces read data only, writes always follow serial clock
// - Interface holds shift registers, config, protocol
// - Sample inputs separately, convert their difference
// - Status low during conversion, strobe mirrors it while deselected
// - Strobe rising edge marks conversion end
// - Acquisition after power-up, reset, each conversion
// - Start on rising edge; ignore until done
module asrc_ctrl
  import asrc_pkg::*;
#(
  parameter int unsigned RST_EXIT_CYCLES = RST_EXIT_CYC
)
(
  // Clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    nrst_i,
  // Host control pins
  input  wire logic                    convert_start_input_i,
  input  wire logic                    sclk_i,
  input  wire logic                    cs_n_i,
  input  wire logic                    sdi_i,
  // Clock source selection for the output shift path
  input  wire logic [1:0]              xfer_clk_sel_i,
  // Analog sample codes seen on the inputs
  input  wire logic signed [17:0]      positive_analog_input_i,
  input  wire logic signed [17:0]      negative_analog_input_i,
  // Status and data
  output logic                         ready_strobe_output_o,
  output logic                         serial_data_outputs_o,
  output logic                         serial_data_outputs_oe_n_o,
  output logic [RES_W-1:0]             result_o,
  output logic [1:0]                   state_o,
  output logic [7:0]                   config_o
);
  import asrc_pkg::*;

  typedef struct packed
  {
    asrc_state_e        state;
    logic               rst_sync1;
    logic               rst_sync2;
    logic [CNT_W-1:0]   exit_cnt;
    logic               exit_done;
    logic [2:0]         cvs_pipe;
    logic [2:0]         sck_pipe;
    logic [2:0]         cs_pipe;
    logic [2:0]         sdi_pipe;
    logic               cvs_q;
    logic               sck_q;
    logic               cs_q;
    logic               start;
    logic               strobe;
    logic [19:0]        in_shift;
    logic [19:0]        out_shift;
    logic [4:0]         bit_cnt;
    logic [7:0]         cfg;
    logic               sdo;
    logic               sdo_oe_n;
    logic [15:0]        result;
  } asrc_top_s;

  asrc_top_s r;
  asrc_top_s next_r;

  logic              core_status;
  logic              core_done;
  logic [RES_W-1:0]  core_result;

  // Stable level once the second and third stages agree
  function automatic logic settled(input logic [2:0] p, input logic prev);
    settled = (p[1] == p[2]) ? p[2] : prev;
  endfunction

  // Converter core gets the synchronised reset and start
  asrc_converter u_conv
  (
    .core_clk_i                 (core_clk_i),
    .nrst_i                     (nrst_i),
    .rst_sync_n_i               (r.exit_done),
    .start_i                    (r.start),
    .pos_sample_i               (positive_analog_input_i),
    .neg_sample_i               (negative_analog_input_i),
    .conversion_active_status_o (core_status),
    .done_o                     (core_done),
    .result_o                   (core_result)
  );

  localparam logic [CNT_W-1:0] EXIT_C = CNT_W'(RST_EXIT_CYCLES);

  logic cvs_lvl;
  logic sck_lvl;
  logic cs_lvl;
  logic sck_rise;
  logic xfer_tick;

  always_comb
  begin
    next_r = r;
    next_r.start = 1'b0;

    // Three-stage pin synchronisers
    next_r.cvs_pipe = {r.cvs_pipe[1:0], convert_start_input_i};
    next_r.sck_pipe = {r.sck_pipe[1:0], sclk_i};
    next_r.cs_pipe  = {r.cs_pipe[1:0], cs_n_i};
    next_r.sdi_pipe = {r.sdi_pipe[1:0], sdi_i};
    cvs_lvl = settled(r.cvs_pipe, r.cvs_q);
    sck_lvl = settled(r.sck_pipe, r.sck_q);
    cs_lvl  = settled(r.cs_pipe, r.cs_q);
    next_r.cvs_q = cvs_lvl;
    next_r.sck_q = sck_lvl;
    next_r.cs_q  = cs_lvl;
    sck_rise = sck_lvl && !r.sck_q;
    // Transfer pacing: internal, serial clock, or either
    case (xfer_clk_sel_i)
      2'b00:   xfer_tick = 1'b1;
      2'b01:   xfer_tick = sck_rise;
      default: xfer_tick = sck_rise || r.bit_cnt[0];
    endcase

    // Release of reset passes a two-stage synchroniser first
    next_r.rst_sync1 = 1'b1;
    next_r.rst_sync2 = r.rst_sync1;

    unique case (r.state)
      ST_RESET:
      begin
        next_r.strobe = 1'b0;
        if (r.rst_sync2)
        begin
          if (r.exit_cnt >= EXIT_C - CNT_W'(1))
          begin
            next_r.state     = ST_ACQ;
            next_r.exit_done = 1'b1;
            next_r.strobe    = 1'b1;
          end
          else
          begin
            next_r.exit_cnt = r.exit_cnt + CNT_W'(1);
          end
        end
      end
      ST_ACQ:
      begin
        // Only a rising convert-start moves on
        if (cvs_lvl && !r.cvs_q)
        begin
          next_r.state = ST_CONV;
          next_r.start = 1'b1;
        end
      end
      ST_CONV:
      begin
        // Convert-start ignored here; core ends on its own
        if (core_done)
        begin
          next_r.state  = ST_ACQ;
          next_r.result = core_result;
        end
      end
      default:
      begin
        next_r.state = ST_RESET;
      end
    endcase

    // Strobe mirrors converter status while deselected
    if (r.state != ST_RESET && r.cs_q)
      next_r.strobe = core_status && !(r.state == ST_CONV && !core_done);
    else if (r.state != ST_RESET)
      next_r.strobe = 1'b0;

    // Minimal shift path and frame handling
    if (r.state == ST_RESET || cs_lvl)
    begin
      next_r.sdo_oe_n = 1'b1;
      next_r.bit_cnt  = '0;
      next_r.out_shift = {r.result, 4'h0};
      if (r.cs_q == 1'b0 && r.bit_cnt == 5'd20 && r.in_shift[19:12] == 8'ha0)
        next_r.cfg = r.in_shift[7:0];
    end
    else
    begin
      next_r.sdo_oe_n = 1'b0;
      if (!r.cs_q == 1'b0)
      begin
        next_r.in_shift = '0;
      end
      else
      begin
        // Writes always follow the serial clock; pacing only moves read data
        if (sck_rise && r.bit_cnt < 5'd20)
        begin
          next_r.in_shift = {r.in_shift[18:0], r.sdi_pipe[2]};
          next_r.bit_cnt  = r.bit_cnt + 5'd1;
        end
        if (xfer_tick)
        begin
          next_r.out_shift = {r.out_shift[18:0], 1'b0};
          next_r.sdo       = r.out_shift[19];
        end
      end
    end
  end

  // Asynchronous entry to reset, all fields constant
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      r <= '{state: ST_RESET, rst_sync1: 1'b0, rst_sync2: 1'b0,
             exit_cnt: '0, exit_done: 1'b0, cvs_pipe: '0, sck_pipe: '0,
             cs_pipe: 3'b111, sdi_pipe: '0, cvs_q: 1'b0, sck_q: 1'b0,
             cs_q: 1'b1, start: 1'b0, strobe: 1'b0, in_shift: '0,
             out_shift: '0, bit_cnt: '0, cfg: CFG_DEFAULT, sdo: 1'b0,
             sdo_oe_n: 1'b1, result: CODE_ZERO};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign ready_strobe_output_o      = r.strobe;
  assign serial_data_outputs_o      = r.sdo;
  assign serial_data_outputs_oe_n_o = r.sdo_oe_n;
  assign result_o                   = r.result;
  assign state_o                    = r.state;
  assign config_o                   = r.cfg;

endmodule

// [tb/asrc_host_model.sv]
// Host controller model driving the converter control pins
module asrc_host_model
(
  // Clock
  input  wire logic core_clk_i,
  // Read data back from the block
  input  wire logic sdo_i,
  // Host pins
  output logic      convert_start_o,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Word read back during the last frame
  logic [19:0] rd_word;

  // Pins idle from time zero so reset exit sees them quiet
  initial
  begin
    convert_start_o = 1'b0;
    sclk_o          = 1'b0;
    cs_n_o          = 1'b1;
    sdi_o           = 1'b0;
  end

  // Low tail of two cycles so a following edge is seen
  task automatic start_conv(input int hold);
    @(posedge core_clk_i) convert_start_o <= 1'b1;
    repeat (hold) @(posedge core_clk_i);
    convert_start_o <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask

  // 20-bit frame, first bit highest, data changed while sclk low
  task automatic frame(input logic [19:0] word);
    @(posedge core_clk_i) cs_n_o <= 1'b0;
    rd_word = '0;
    for (int i = 19; i >= 0; i--)
    begin
      repeat (3) @(posedge core_clk_i);
      sdi_o  <= word[i];
      repeat (3) @(posedge core_clk_i);
      sclk_o <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      sclk_o <= 1'b0;
      // Bit launched at the rising serial clock has settled by now
      repeat (3) @(posedge core_clk_i);
      rd_word[i] = sdo_i;
    end
    repeat (3) @(posedge core_clk_i);
    cs_n_o <= 1'b1;
    // Released line must not keep showing the last bit
    sdi_o  <= ~sdi_o;
  endtask
endmodule

// [tb/asrc_ctrl_assertions.sv]
// Concurrent checks on the ports of the converter control top
module asrc_ctrl_assertions
  import asrc_pkg::*;
(
  // Clock and reset
  input wire logic                core_clk_i,
  input wire logic                nrst_i,
  // Host pins
  input wire logic                convert_start_input_i,
  input wire logic                sclk_i,
  input wire logic                cs_n_i,
  input wire logic                sdi_i,
  input wire logic [1:0]          xfer_clk_sel_i,
  input wire logic signed [17:0]  positive_analog_input_i,
  input wire logic signed [17:0]  negative_analog_input_i,
  // Design outputs
  input wire logic                ready_strobe_output_o,
  input wire logic                serial_data_outputs_o,
  input wire logic                serial_data_outputs_oe_n_o,
  input wire logic [RES_W-1:0]    result_o,
  input wire logic [1:0]          state_o,
  input wire logic [7:0]          config_o
);
  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  state_legal_a: assert property (state_o != 2'b11)
    else $error("state code outside the three states");
  reset_quiet_a: assert property (state_o == 2'b00 |-> !ready_strobe_output_o
    && serial_data_outputs_oe_n_o && config_o == CFG_DEFAULT)
    else $error("reset state not quiet");
  exit_strobe_a: assert property (state_o == 2'b00 ##1 state_o == 2'b01
    |-> ##[0:1] ready_strobe_output_o)
    else $error("strobe not high on acquisition entry");
  conv_strobe_a: assert property (state_o == 2'b10 ##1 state_o == 2'b10
    |-> !ready_strobe_output_o)
    else $error("strobe high during conversion");
  conv_length_a: assert property ($rose(state_o == 2'b10)
    |-> (state_o == 2'b10)[*8] ##[1:7] state_o == 2'b01)
    else $error("conversion length out of bounds");
  conv_end_a: assert property (state_o == 2'b10 ##1 state_o != 2'b10
    |-> state_o == 2'b01)
    else $error("conversion did not end in acquisition");
  strobe_rise_a: assert property ($rose(ready_strobe_output_o) |-> state_o == 2'b01)
    else $error("strobe rose outside acquisition");
  sdo_release_a: assert property (cs_n_i[*6] |-> serial_data_outputs_oe_n_o)
    else $error("data output driven while deselected");
endmodule

bind asrc_ctrl asrc_ctrl_assertions i_chk (.core_clk_i, .nrst_i, .convert_start_input_i,
  .sclk_i, .cs_n_i, .sdi_i, .xfer_clk_sel_i, .positive_analog_input_i,
  .negative_analog_input_i, .ready_strobe_output_o, .serial_data_outputs_o,
  .serial_data_outputs_oe_n_o, .result_o, .state_o, .config_o);

// [tb/asrc_ctrl_bench.sv]
// Self-checking bench for the converter state and reset control
module asrc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import asrc_pkg::*;

  logic               core_clk;
  logic               nrst;
  logic [1:0]         xfer_sel;
  logic signed [17:0] pos_in;
  logic signed [17:0] neg_in;
  wire logic          conv_pin;
  wire logic          sclk_pin;
  wire logic          cs_n_pin;
  wire logic          sdi_pin;
  logic               strobe;
  logic               oe_n;
  logic               sdo_pin;
  logic [15:0]        result;
  logic [1:0]         state;
  logic [7:0]         cfg;
  int                 num_errors = 0;
  int                 num_checks = 0;
  int                 c;

  asrc_ctrl #(.RST_EXIT_CYCLES(2)) i_dut (.core_clk_i(core_clk), .nrst_i(nrst),
    .convert_start_input_i(conv_pin), .sclk_i(sclk_pin), .cs_n_i(cs_n_pin),
    .sdi_i(sdi_pin), .xfer_clk_sel_i(xfer_sel), .positive_analog_input_i(pos_in),
    .negative_analog_input_i(neg_in), .ready_strobe_output_o(strobe),
    .serial_data_outputs_o(sdo_pin), .serial_data_outputs_oe_n_o(oe_n), .result_o(result),
    .state_o(state), .config_o(cfg));

  asrc_host_model i_host (.core_clk_i(core_clk), .sdo_i(sdo_pin), .convert_start_o(conv_pin),
    .sclk_o(sclk_pin), .cs_n_o(cs_n_pin), .sdi_o(sdi_pin));

  always #25 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Bounded wait for a strobe level, cycles counted in c
  task automatic wait_strobe(input logic lvl);
    c = 0;
    while (strobe !== lvl)
    begin
      @(posedge core_clk);
      #1;
      c++;
      if (c > 100)
      begin
        num_errors++;
        $display("Error at %0t ns: strobe wait ran out", $time);
        stop_test();
      end
    end
  endtask

  task automatic t_release();
    @(posedge core_clk) nrst <= 1'b1;
    #1;
    chk(16'(state), 16'h0000);
    wait_strobe(1'b1);
    chk(16'(c >= 2), 16'h0001);
    chk(16'(state), 16'h0001);
  endtask

  task automatic t_conv(input logic signed [17:0] p, input logic signed [17:0] n,
                        input logic [15:0] exp);
    @(posedge core_clk) pos_in <= p;
    neg_in <= n;
    i_host.start_conv(4);
    wait_strobe(1'b0);
    wait_strobe(1'b1);
    chk(16'(c >= CONV_MIN_CYC - 3 && c <= CONV_MAX_CYC + 2), 16'h0001);
    chk(result, exp);
    chk(16'(state), 16'h0001);
  endtask

  // Second edge lands inside the conversion; no conversion may follow it
  task automatic t_ignore();
    i_host.start_conv(2);
    i_host.start_conv(2);
    wait_strobe(1'b1);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge core_clk);
      #1;
      chk(16'(state), 16'h0001);
      chk(16'(strobe), 16'h0001);
    end
  endtask

  // Write frame at one pacing; read data judged when the serial clock paces it
  task automatic t_frame(input logic [1:0] sel, input logic [7:0] data);
    @(posedge core_clk) xfer_sel <= sel;
    fork
      i_host.frame({12'ha00, data});
    join_none
    repeat (8) @(posedge core_clk);
    #1;
    chk(16'(oe_n), 16'h0000);
    chk(16'(strobe), 16'h0000);
    wait fork;
    repeat (8) @(posedge core_clk);
    #1;
    chk(16'(oe_n), 16'h0001);
    chk(16'(cfg), {8'h00, data});
    chk(16'(strobe), 16'h0001);
    if (sel == 2'b01)
    begin
      chk(i_host.rd_word[19:4], 16'h8000);
      chk(16'(i_host.rd_word[3:0]), 16'h0000);
    end
  endtask

  // Reset dropped in mid-conversion, checked before the next clock edge
  task automatic t_abort();
    i_host.start_conv(4);
    wait_strobe(1'b0);
    @(posedge core_clk) nrst <= 1'b0;
    #5;
    chk(16'(state), 16'h0000);
    chk(16'(strobe), 16'h0000);
    chk(16'(oe_n), 16'h0001);
    chk(16'(cfg), 16'h0000);
    repeat (12) @(posedge core_clk);
    t_release();
  endtask

  initial
  begin
    core_clk = 1'b0;
    nrst     = 1'b0;
    xfer_sel = 2'b01;
    pos_in   = '0;
    neg_in   = '0;
    repeat (12) @(posedge core_clk);
    #1;
    chk(16'(strobe), 16'h0000);
    chk(result, 16'h0000);
    t_release();
    t_conv(18'sd0, 18'sd0, 16'h0000);
    t_conv(18'sd1, 18'sd0, 16'h0001);
    t_conv(18'sd0, 18'sd1, 16'hffff);
    t_conv(18'sd32767, 18'sd0, 16'h7fff);
    t_conv(18'sd40000, 18'sd0, 16'h7fff);
    t_conv(-18'sd20000, 18'sd20000, 16'h8000);
    t_ignore();
    t_frame(2'b01, 8'h5c);
    t_frame(2'b00, 8'h33);
    t_frame(2'b10, 8'ha5);
    t_abort();
    stop_test();
  end
endmodule
